/* File: common/svx_pkg.sv */
// types shared by the vector unit and its bench
// assumes the register header is included beside it
package svx_pkg;
  // ==========================================================
  // issued operations
  typedef enum logic [3:0] {
    OP_ADDS, OP_ADDU, OP_SUBU, OP_ADDM, OP_MULF, OP_MACG, OP_MACGU,
    OP_CMPEQ, OP_CMPGTS, OP_CMPGTU, OP_SEL, OP_LDST,
    OP_FABSS, OP_FABSV, OP_FABSD
  } svx_op_t;
  // interrupt causes
  typedef enum logic [2:0] {
    IRQ_NONE, IRQ_ALIGN, IRQ_UNAVAIL, IRQ_FPDATA, IRQ_FPROUND
  } svx_irq_t;
endpackage

/* File: common/svx_regs.svh */
// register numbers, field positions and reset values of the vector unit
// assumes a 10-bit special register number and 32-bit register words
`ifndef SVX_REGS_SVH
`define SVX_REGS_SVH
// ==========================================================
// special register numbers
`define SVX_SPR_ALIGN 10'h195
`define SVX_SPR_UNAVAIL 10'h210
`define SVX_SPR_FPDATA 10'h211
`define SVX_SPR_FPROUND 10'h212
`define SVX_SPR_PREFIX 10'h3F0
`define SVX_SPR_STATUS 10'h3F1
// ==========================================================
// status word fields (64-bit bit n sits at word bit 63-n)
`define SVX_ST_SOV 15
`define SVX_ST_OV 14
`define SVX_ST_OVH 30
`define SVX_ST_RNDEN 6
`define SVX_ST_DATEN 5
// ==========================================================
// vector address forming
`define SVX_PFX_LSB 16
`define SVX_OFF_LSB 4
`define SVX_ALIGN_MASK 3'h7
// ==========================================================
// sign bits and reset values
`define SVX_SIGN_HI 63
`define SVX_SIGN_LO 31
`define SVX_RST_WORD 32'h0000_0000
`define SVX_RST_WIDE 64'h0000_0000_0000_0000
`endif

/* File: logic/svx_unit.sv */
// two-element vector datapath with its trap vectoring and overflow status
// assumes the core issues one op a cycle and owns the condition register
// Summary of operation
// - misaligned vector load or store vectors through the alignment offset
// - unit-unavailable trap takes its offset from its own register
// - float data and float round traps each use their own offset
// - any vector-related trap sets the vector syndrome bit
// - compares write a condition field; select reads condition bits
// - unit disabled: issued op traps instead of executing
// - ops work on two 32-bit elements; accumulator chains accumulates
// - 64-bit operands move only through the vector load/store op
// - vector single and double use 64 bits; scalar single low word
// - unsigned result above max or below zero sets element overflow
// - signed result outside two's-complement range sets element overflow
// - unsigned fraction point left of msb; out of range may overflow
// - unsigned fractions use the unsigned integer ops, no own ops
// - guarded unsigned fraction 64 bits, always wraps, no overflow
// - signed fraction point right of sign; out of range may overflow
// - signed fraction product shifts left one, zero into lsb
// - guarded signed fraction 64 bits, always wraps, no overflow
// - low overflow set or cleared per result; modulo ops keep it
// - summary overflow set with low overflow, sticky until written zero
`include "svx_regs.svh"
module svx_unit
  import svx_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic sprWrEn,
  input wire logic sprRdEn,
  input wire logic [9:0] sprNum,
  input wire logic [31:0] sprWrData,
  output logic [31:0] sprRdData,
  input wire logic issueValid,
  input wire svx_op_t issueOp,
  input wire logic [63:0] opA,
  input wire logic [63:0] opB,
  input wire logic [2:0] crFieldSel,
  input wire logic [3:0] crIn,
  input wire logic msrAvail,
  input wire logic fpInexact,
  input wire logic otherIrq,
  output logic resValid,
  output logic [63:0] result,
  output logic [63:0] acc,
  output logic crWrEn,
  output logic [2:0] crFieldOut,
  output logic [3:0] crValue,
  output logic irqTake,
  output logic [31:0] irqVector,
  output logic vecSyndrome,
  output logic ovLow,
  output logic ovHigh,
  output logic sumOv
);
  // ==========================================================
  // element helpers
  // add or subtract with saturation; returns {overflow, value}
  function automatic logic [32:0] satAdd(input logic [31:0] a,
    input logic [31:0] b, input logic sgn, input logic sub);
    logic [32:0] s;
    logic [31:0] bb;
    logic ov;
    logic [31:0] sat;
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {32'h0000_0000, sub};
    if (sgn)
    begin
      ov = (a[31] == bb[31]) && (s[31] != a[31]);
      sat = a[31] ? {1'b1, 31'h0000_0000} : {1'b0, 31'h7FFF_FFFF};
    end
    else
    begin
      ov = sub ? !s[32] : s[32];
      sat = sub ? 32'h0000_0000 : 32'hFFFF_FFFF;
    end
    satAdd = ov ? {1'b1, sat} : {1'b0, s[31:0]};
  endfunction

  // signed fraction product: redundant sign dropped, zero lsb
  function automatic logic [32:0] fracMul(input logic [15:0] a,
    input logic [15:0] b);
    logic [31:0] p;
    p = $signed(a) * $signed(b);
    if (a == 16'h8000 && b == 16'h8000)
      fracMul = {1'b1, 32'h7FFF_FFFF}; // minus one squared cannot fit
    else
      fracMul = {1'b0, p[30:0], 1'b0};
  endfunction

  // single precision infinity, nan or denorm
  function automatic logic spSpecial(input logic [31:0] f);
    spSpecial = (f[30:23] == 8'hFF) || (f[30:23] == 8'h00 && f[22:0] != 23'h0);
  endfunction

  // ==========================================================
  // registers and datapath wires
  logic [31:0] alignOff;
  logic [31:0] unavailOff;
  logic [31:0] fpDataOff;
  logic [31:0] fpRoundOff;
  logic [31:0] prefix;
  logic fpDataEn;
  logic fpRoundEn;
  logic [63:0] next_res;
  logic [63:0] next_acc;
  logic [3:0] next_cr;
  logic next_ovL;
  logic next_ovH;
  logic setOvL;
  logic setOvH;
  logic keepOv;
  logic crHit;
  logic done;
  svx_irq_t fault;
  logic [32:0] eLo;
  logic [32:0] eHi;
  logic [63:0] gProd;
  logic [31:0] selOff;
  logic stWr;
  logic [31:0] next_rd;

  assign stWr = sprWrEn && sprNum == `SVX_SPR_STATUS;

  // ==========================================================
  // issue decode and element arithmetic
  always_comb
  begin
    next_res = `SVX_RST_WIDE;
    next_acc = acc;
    next_cr = 4'h0;
    setOvL = 1'b0;
    setOvH = 1'b0;
    keepOv = 1'b1;
    crHit = 1'b0;
    done = 1'b0;
    fault = IRQ_NONE;
    eLo = 33'h0_0000_0000;
    eHi = 33'h0_0000_0000;
    gProd = `SVX_RST_WIDE;
    if (issueValid)
    begin
      if (!msrAvail)
        fault = IRQ_UNAVAIL; // nothing executes while unit is off
      else
      begin
        done = 1'b1;
        case (issueOp)
          OP_ADDS, OP_ADDU, OP_SUBU:
          begin
            // per element, high word [63:32] and low word [31:0]
            eLo = satAdd(opA[31:0], opB[31:0], issueOp == OP_ADDS,
              issueOp == OP_SUBU);
            eHi = satAdd(opA[63:32], opB[63:32], issueOp == OP_ADDS,
              issueOp == OP_SUBU);
            next_res = {eHi[31:0], eLo[31:0]};
            keepOv = 1'b0;
          end
          OP_ADDM:
            // modulo wraps and leaves both flags alone
            next_res = {opA[63:32] + opB[63:32], opA[31:0] + opB[31:0]};
          OP_MULF:
          begin
            eLo = fracMul(opA[31:16], opB[31:16]);
            eHi = fracMul(opA[63:48], opB[63:48]);
            next_res = {eHi[31:0], eLo[31:0]};
            keepOv = 1'b0;
          end
          OP_MACG:
          begin
            // guarded signed fraction: sign-extended, wraps mod 2^64
            eLo = fracMul(opA[31:16], opB[31:16]);
            if (opA[31:16] == 16'h8000 && opB[31:16] == 16'h8000)
              gProd = {32'h0000_0000, 32'h8000_0000};
            else
              gProd = {{32{eLo[31]}}, eLo[31:0]};
            next_acc = acc + gProd; // accumulate chains back to back
            next_res = next_acc;
            eLo = 33'h0_0000_0000;
          end
          OP_MACGU:
          begin
            // unsigned fractions ride the unsigned integer form
            // widened first so the full 32-bit product is kept
            gProd = {48'h0000_0000_0000, opA[31:16]} * {48'h0000_0000_0000, opB[31:16]};
            next_acc = acc + gProd; // modulo, no flag
            next_res = next_acc;
          end
          OP_CMPEQ, OP_CMPGTS, OP_CMPGTU:
          begin
            crHit = 1'b1;
            done = 1'b0;
            if (issueOp == OP_CMPEQ)
            begin
              next_cr[3] = opA[63:32] == opB[63:32];
              next_cr[2] = opA[31:0] == opB[31:0];
            end
            else if (issueOp == OP_CMPGTS)
            begin
              next_cr[3] = $signed(opA[63:32]) > $signed(opB[63:32]);
              next_cr[2] = $signed(opA[31:0]) > $signed(opB[31:0]);
            end
            else
            begin
              next_cr[3] = opA[63:32] > opB[63:32];
              next_cr[2] = opA[31:0] > opB[31:0];
            end
            next_cr[1] = next_cr[3] | next_cr[2];
            next_cr[0] = next_cr[3] & next_cr[2]; // field written
          end
          OP_SEL:
            // condition bits pick each element
            next_res = {crIn[3] ? opA[63:32] : opB[63:32],
              crIn[2] ? opA[31:0] : opB[31:0]};
          OP_LDST:
          begin
            // only path for whole 64-bit operands
            if ((opA[2:0] & `SVX_ALIGN_MASK) != 3'h0)
            begin
              fault = IRQ_ALIGN;
              done = 1'b0;
            end
            else
              next_res = opB;
          end
          OP_FABSS, OP_FABSV, OP_FABSD:
          begin
            next_res = opA;
            if (issueOp != OP_FABSD)
              next_res[`SVX_SIGN_LO] = 1'b0; // scalar single: low word
            if (issueOp != OP_FABSS)
              next_res[`SVX_SIGN_HI] = 1'b0; // vector and double: 64 bits
            if (fpDataEn && ((issueOp != OP_FABSD && spSpecial(opA[31:0]))
              || (issueOp == OP_FABSV && spSpecial(opA[63:32]))
              || (issueOp == OP_FABSD && opA[62:52] == 11'h7FF)))
            begin
              fault = IRQ_FPDATA;
              done = 1'b0;
            end
            else if (fpRoundEn && fpInexact)
              fault = IRQ_FPROUND;
          end
          default:
            done = 1'b0;
        endcase
        setOvL = !keepOv && eLo[32];
        setOvH = !keepOv && eHi[32];
      end
    end
  end

  // flags follow each saturating add, subtract or fraction-multiply result, and keep under all other ops
  assign next_ovL = keepOv ? (stWr ? sprWrData[`SVX_ST_OV] : ovLow) : setOvL;
  assign next_ovH = keepOv ? (stWr ? sprWrData[`SVX_ST_OVH] : ovHigh) : setOvH;

  // ==========================================================
  // offset select by cause
  always_comb
  begin
    case (fault)
      IRQ_ALIGN: selOff = alignOff;
      IRQ_UNAVAIL: selOff = unavailOff;
      IRQ_FPDATA: selOff = fpDataOff;
      IRQ_FPROUND: selOff = fpRoundOff;
      default: selOff = `SVX_RST_WORD;
    endcase
  end

  // ==========================================================
  // special registers, software side
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      alignOff <= `SVX_RST_WORD;
      unavailOff <= `SVX_RST_WORD;
      fpDataOff <= `SVX_RST_WORD;
      fpRoundOff <= `SVX_RST_WORD;
      prefix <= `SVX_RST_WORD;
      fpDataEn <= 1'b0;
      fpRoundEn <= 1'b0;
    end
    else if (sprWrEn)
    begin
      case (sprNum)
        `SVX_SPR_ALIGN: alignOff <= sprWrData;
        `SVX_SPR_UNAVAIL: unavailOff <= sprWrData;
        `SVX_SPR_FPDATA: fpDataOff <= sprWrData;
        `SVX_SPR_FPROUND: fpRoundOff <= sprWrData;
        `SVX_SPR_PREFIX: prefix <= sprWrData;
        `SVX_SPR_STATUS:
        begin
          fpDataEn <= sprWrData[`SVX_ST_DATEN];
          fpRoundEn <= sprWrData[`SVX_ST_RNDEN];
        end
        default: prefix <= prefix;
      endcase
    end
  end

  // read mux; unknown numbers read zero
  always_comb
  begin
    next_rd = `SVX_RST_WORD;
    case (sprNum)
      `SVX_SPR_ALIGN: next_rd = alignOff;
      `SVX_SPR_UNAVAIL: next_rd = unavailOff;
      `SVX_SPR_FPDATA: next_rd = fpDataOff;
      `SVX_SPR_FPROUND: next_rd = fpRoundOff;
      `SVX_SPR_PREFIX: next_rd = prefix;
      `SVX_SPR_STATUS:
      begin
        next_rd[`SVX_ST_SOV] = sumOv;
        next_rd[`SVX_ST_OV] = ovLow;
        next_rd[`SVX_ST_OVH] = ovHigh;
        next_rd[`SVX_ST_DATEN] = fpDataEn;
        next_rd[`SVX_ST_RNDEN] = fpRoundEn;
      end
      default: next_rd = `SVX_RST_WORD;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      sprRdData <= `SVX_RST_WORD;
    else if (sprRdEn)
      sprRdData <= next_rd;
  end

  // ==========================================================
  // overflow status; hardware set beats a software clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ovLow <= 1'b0;
      ovHigh <= 1'b0;
      sumOv <= 1'b0;
    end
    else
    begin
      ovLow <= next_ovL;
      ovHigh <= next_ovH;
      if (setOvL)
        sumOv <= 1'b1;
      else if (stWr)
        sumOv <= sprWrData[`SVX_ST_SOV]; // sticky until zero written
    end
  end

  // ==========================================================
  // results, accumulator and condition field
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      resValid <= 1'b0;
      result <= `SVX_RST_WIDE;
      acc <= `SVX_RST_WIDE;
      crWrEn <= 1'b0;
      crFieldOut <= 3'h0;
      crValue <= 4'h0;
    end
    else
    begin
      resValid <= done;
      result <= done ? next_res : result;
      if (done)
        acc <= next_acc;
      crWrEn <= crHit;
      crFieldOut <= crHit ? crFieldSel : crFieldOut;
      crValue <= crHit ? next_cr : crValue;
    end
  end

  // ==========================================================
  // trap vectoring and syndrome
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      irqTake <= 1'b0;
      irqVector <= `SVX_RST_WORD;
      vecSyndrome <= 1'b0;
    end
    else
    begin
      irqTake <= fault != IRQ_NONE;
      if (fault != IRQ_NONE)
        irqVector <= {prefix[31:`SVX_PFX_LSB], selOff[`SVX_PFX_LSB-1:`SVX_OFF_LSB],
          4'h0};
      // a vector trap in the same cycle beats the clear
      if (fault != IRQ_NONE)
        vecSyndrome <= 1'b1;
      else if (otherIrq)
        vecSyndrome <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_issueOn;
    issueValid && msrAvail;
  endsequence
  sequence s_trapOut(logic [31:0] off);
    irqTake && irqVector[15:4] == off[15:4];
  endsequence

  a_unavail_traps: assert property (issueValid && !msrAvail |=>
    s_trapOut(unavailOff) and !resValid and !crWrEn)
    else $error("disabled unit executed an op");
  a_align_vector: assert property (s_issueOn ##0 (issueOp == OP_LDST &&
    opA[2:0] != 3'h0 && !sprWrEn) |=> s_trapOut(alignOff) and !resValid)
    else $error("misaligned access not vectored");
  a_syndrome_set: assert property (irqTake |-> vecSyndrome)
    else $error("trap without syndrome bit");
  a_prefix_join: assert property (irqTake |->
    irqVector[31:16] == $past(prefix[31:16]) && irqVector[3:0] == 4'h0)
    else $error("handler address not from prefix");
  a_sov_follows: assert property (setOvL |=> sumOv && ovLow)
    else $error("overflow not summarised");
  a_sov_sticky: assert property (sumOv && !(stWr && !sprWrData[`SVX_ST_SOV]) |=> sumOv)
    else $error("summary overflow dropped");
  a_modulo_keeps: assert property (s_issueOn ##0 (issueOp inside {OP_MACG,
    OP_MACGU, OP_ADDM} && !stWr) |=> $stable(ovLow) && $stable(ovHigh))
    else $error("modulo op touched overflow");
  a_frac_shift: assert property (s_issueOn ##0 issueOp == OP_MULF |=>
    resValid && (!result[0] || ovLow) && (!result[32] || ovHigh))
    else $error("fraction product lsb not zero");
  a_cmp_field: assert property (s_issueOn ##0 issueOp == OP_CMPEQ &&
    opA == opB |=> crWrEn && crValue == 4'hF && crFieldOut == $past(crFieldSel))
    else $error("compare field wrong");
  a_unsigned_sat: assert property (s_issueOn ##0 (issueOp == OP_ADDU &&
    opA[31:0] == 32'hFFFF_FFFF && opB[31:0] != 32'h0) |=>
    ovLow && result[31:0] == 32'hFFFF_FFFF)
    else $error("unsigned overflow missed");
endmodule // svx_unit

/* File: testbench/svx_core_model.sv */
// core-side partner: holds the condition register fields
// assumes compare results arrive as one-cycle write pulses
module svx_core_model
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic crWrEn,
  input wire logic [2:0] crFieldOut,
  input wire logic [3:0] crValue,
  input wire logic [2:0] readSel,
  output logic [3:0] crOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] fields [8];
  // ==========================================================
  // field storage; compares write it, select reads it back
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 8; i++)
        fields[i] <= 4'h0;
    end
    else if (crWrEn)
      fields[crFieldOut] <= crValue;
  end
  // combinational read, as the core presents a source field
  assign crOut = fields[readSel];
endmodule // svx_core_model

/* File: testbench/svx_unit_tb.sv */
// self-checking bench for the vector unit: registers, ops, flags, traps
// assumes the core-side model owns the condition register
`include "svx_regs.svh"
module svx_unit_tb
  import svx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PFX = 32'hABCD_1234;
  localparam logic [31:0] OFF_AL = 32'h0000_0150;
  localparam logic [31:0] OFF_UN = 32'h0000_0260;
  localparam logic [31:0] OFF_FD = 32'h0000_0370;
  localparam logic [31:0] OFF_FR = 32'h0000_0480;
  localparam int LIMIT = 1000;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic sprWrEn = 1'b0;
  logic sprRdEn = 1'b0;
  logic [9:0] sprNum = 10'h000;
  logic [31:0] sprWrData = 32'h0;
  logic issueValid = 1'b0;
  svx_op_t issueOp = OP_ADDU;
  logic [63:0] opA = 64'h0;
  logic [63:0] opB = 64'h0;
  logic [2:0] crFieldSel = 3'h0;
  logic [2:0] readSel = 3'h0;
  logic msrAvail = 1'b1;
  logic fpInexact = 1'b0;
  logic otherIrq = 1'b0;
  logic [3:0] crIn;
  logic [31:0] sprRdData, irqVector, rdv;
  logic [63:0] result, acc;
  logic resValid, crWrEn, irqTake, vecSyndrome, ovLow, ovHigh, sumOv;
  logic [2:0] crFieldOut;
  logic [3:0] crValue;
  int numErrors = 0;
  int checks = 0;
  int cycles = 0;

  svx_unit i_svx_unit (.clock(clock), .nrst(nrst), .sprWrEn(sprWrEn), .sprRdEn(sprRdEn),
    .sprNum(sprNum), .sprWrData(sprWrData), .sprRdData(sprRdData), .issueValid(issueValid),
    .issueOp(issueOp), .opA(opA), .opB(opB), .crFieldSel(crFieldSel), .crIn(crIn),
    .msrAvail(msrAvail), .fpInexact(fpInexact), .otherIrq(otherIrq), .resValid(resValid),
    .result(result), .acc(acc), .crWrEn(crWrEn), .crFieldOut(crFieldOut),
    .crValue(crValue), .irqTake(irqTake), .irqVector(irqVector),
    .vecSyndrome(vecSyndrome), .ovLow(ovLow), .ovHigh(ovHigh), .sumOv(sumOv));
  svx_core_model i_svx_core_model (.clock(clock), .nrst(nrst), .crWrEn(crWrEn),
    .crFieldOut(crFieldOut), .crValue(crValue), .readSel(readSel), .crOut(crIn));

  // ==========================================================
  // clock and hang guard
  always #2.5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      numErrors++;
      $display("timeout after %0d cycles", cycles);
      tally_and_finish();
    end
  end

  // ==========================================================
  // shared tasks; every request starts 1 ns after a rising edge
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    if (seen !== exp)
      numErrors++;
  endtask
  task automatic wr(input logic [9:0] n, input logic [31:0] d);
    sprWrEn = 1'b1;
    sprNum = n;
    sprWrData = d;
    @(posedge clock);
    #1;
    sprWrEn = 1'b0;
  endtask
  task automatic rd(input logic [9:0] n, output logic [31:0] d);
    sprRdEn = 1'b1;
    sprNum = n;
    @(posedge clock);
    #1;
    sprRdEn = 1'b0;
    d = sprRdData;
  endtask
  // pulse outputs are looked at in the cycle after the taking edge;
  // one idle edge first so back-to-back calls never retoggle the strobe
  task automatic issue(input svx_op_t op, input logic [63:0] a, input logic [63:0] b);
    @(posedge clock);
    #1;
    issueValid = 1'b1;
    issueOp = op;
    opA = a;
    opB = b;
    @(posedge clock);
    #1;
    issueValid = 1'b0;
  endtask
  task automatic regchk(input logic [9:0] n, input logic [31:0] v);
    wr(n, v);
    rd(n, rdv);
    chk(rdv, v);
  endtask
  // handler address: prefix upper half, offset bits 15..4
  function automatic logic [31:0] vec(input logic [31:0] off);
    return {PFX[31:16], off[15:4], 4'h0};
  endfunction
  task automatic trap(input logic [31:0] off, input logic res);
    chk(irqTake, 1'b1);
    chk(irqVector, vec(off));
    chk(resValid, res);
    chk(vecSyndrome, 1'b1);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    #1;
    nrst = 1'b1;
    rd(`SVX_SPR_ALIGN, rdv);
    chk(rdv, `SVX_RST_WORD);
    regchk(`SVX_SPR_ALIGN, OFF_AL);
    regchk(`SVX_SPR_UNAVAIL, OFF_UN);
    regchk(`SVX_SPR_FPDATA, OFF_FD);
    regchk(`SVX_SPR_FPROUND, OFF_FR);
    regchk(`SVX_SPR_PREFIX, PFX);
    wr(10'h100, 32'hFFFF_FFFF);
    rd(10'h100, rdv);
    chk(rdv, 32'h0);
    $display("test registers done");
    // saturation limits on each element, sticky summary
    issue(OP_ADDU, {32'h1, 32'hFFFF_FFFF}, {32'h1, 32'h1});
    chk(result, {32'h2, 32'hFFFF_FFFF});
    chk({ovHigh, ovLow, sumOv}, 3'b011);
    issue(OP_ADDU, {32'hFFFF_FFFF, 32'h1}, {32'h1, 32'h1});
    chk({ovHigh, ovLow, sumOv}, 3'b101);
    issue(OP_SUBU, {32'h5, 32'h0}, {32'h1, 32'h1});
    chk(result, {32'h4, 32'h0});
    chk({ovHigh, ovLow}, 2'b01);
    issue(OP_ADDS, {32'h8000_0000, 32'h7FFF_FFFF}, {32'hFFFF_FFFF, 32'h1});
    chk(result, {32'h8000_0000, 32'h7FFF_FFFF});
    chk({ovHigh, ovLow}, 2'b11);
    issue(OP_ADDM, {32'h0, 32'hFFFF_FFFF}, {32'h0, 32'h2});
    chk(result, {32'h0, 32'h1});
    chk({ovHigh, ovLow}, 2'b11);
    rd(`SVX_SPR_STATUS, rdv);
    chk(rdv, 32'h4000_C000);
    wr(`SVX_SPR_STATUS, 32'h0000_0060);
    rd(`SVX_SPR_STATUS, rdv);
    chk(rdv, 32'h0000_0060);
    chk(sumOv, 1'b0);
    $display("test overflow done");
    // fractions: shifted product, saturating corner, guarded wrap
    issue(OP_MULF, 64'h4000_0000_8000_0000, 64'h4000_0000_8000_0000);
    chk(result, {32'h2000_0000, 32'h7FFF_FFFF});
    chk({ovHigh, ovLow}, 2'b01);
    issue(OP_MACG, 64'h8000_0000, 64'h8000_0000);
    chk(acc, 64'h0000_0000_8000_0000);
    issue(OP_MACG, 64'h8000_0000, 64'h4000_0000);
    chk(acc, 64'h0000_0000_4000_0000);
    chk(result, 64'h0000_0000_4000_0000);
    chk({ovHigh, ovLow}, 2'b01);
    issue(OP_MACGU, 64'hFFFF_0000, 64'hFFFF_0000);
    chk(acc, 64'h0000_0001_3FFE_0001);
    chk({ovHigh, ovLow}, 2'b01);
    $display("test fractions done");
    // compares into fields, select from a stored field
    crFieldSel = 3'h2;
    issue(OP_CMPEQ, {32'h5, 32'h6}, {32'h5, 32'h7});
    chk({crWrEn, crFieldOut, crValue}, {1'b1, 3'h2, 4'hA});
    crFieldSel = 3'h5;
    issue(OP_CMPGTS, {32'hFFFF_FFFF, 32'h1}, 64'h0);
    chk({crWrEn, crFieldOut, crValue}, {1'b1, 3'h5, 4'h6});
    issue(OP_CMPGTU, {32'hFFFF_FFFF, 32'h1}, 64'h0);
    chk(crValue, 4'hF);
    issue(OP_CMPEQ, 64'h9, 64'h9);
    chk({crWrEn, crFieldOut, crValue}, {1'b1, 3'h5, 4'hF});
    readSel = 3'h2;
    issue(OP_SEL, 64'h1111_1111_2222_2222, 64'h3333_3333_4444_4444);
    chk(result, 64'h1111_1111_4444_4444);
    $display("test condition done");
    // traps and their handler addresses
    issue(OP_LDST, 64'h3, 64'h0);
    trap(OFF_AL, 1'b0);
    otherIrq = 1'b1;
    @(posedge clock);
    #1;
    otherIrq = 1'b0;
    chk(vecSyndrome, 1'b0);
    msrAvail = 1'b0;
    issue(OP_ADDU, 64'h1, 64'h1);
    msrAvail = 1'b1;
    trap(OFF_UN, 1'b0);
    issue(OP_FABSS, 64'h7F80_0000, 64'h0);
    trap(OFF_FD, 1'b0);
    fpInexact = 1'b1;
    issue(OP_FABSS, 64'hBF80_0000, 64'h0);
    fpInexact = 1'b0;
    trap(OFF_FR, 1'b1);
    chk(result[31:0], 32'h3F80_0000);
    issue(OP_FABSV, 64'hBF80_0000_C000_0000, 64'h0);
    chk(result, 64'h3F80_0000_4000_0000);
    chk(irqTake, 1'b0);
    issue(OP_FABSD, 64'hC000_0000_0000_0001, 64'h0);
    chk(result, 64'h4000_0000_0000_0001);
    issue(OP_LDST, 64'h8, 64'h1234);
    chk({resValid, irqTake}, 2'b10);
    chk(result, 64'h1234);
    $display("test traps done");
    // mid-run reset drops flags, accumulator, syndrome and offsets
    nrst = 1'b0;
    @(posedge clock);
    #1;
    chk(acc, 64'h0);
    chk({resValid, irqTake, vecSyndrome, sumOv, ovLow, ovHigh}, 6'h00);
    nrst = 1'b1;
    rd(`SVX_SPR_ALIGN, rdv);
    chk(rdv, `SVX_RST_WORD);
    $display("test reset done");
    tally_and_finish();
  end
endmodule // svx_unit_tb
